// file: logic/lpc_pkg.sv
// Shared constants for the low pin count target and its host end.
// Assumes both ends run on one common bus clock, sys_clk.
package lpc_pkg;

  // ==========================================================
  // Field encodings
  // ==========================================================
  localparam logic [3:0] START_FW_WRITE = 4'he;
  localparam logic [3:0] START_LPC_MEM  = 4'h0;
  localparam logic [1:0] CYCTYPE_MEM    = 2'h1;
  localparam logic       DIR_READ       = 1'h0;
  localparam logic [3:0] SIZE_ONE_BYTE  = 4'h0;
  localparam logic [3:0] SYNC_READY     = 4'h0;
  localparam logic [3:0] NIBBLE_ONES    = 4'hf;
  localparam logic [3:0] CYC_MEM_READ   = 4'h4;

  // ==========================================================
  // Clock numbers within a frame (clock 1 carries the start field)
  // ==========================================================
  localparam logic [4:0] CLK_SELECT     = 5'h02;
  localparam logic [4:0] FW_ADDR_LAST   = 5'h09;
  localparam logic [4:0] FW_SIZE_CLK    = 5'h0a;
  localparam logic [4:0] FW_DATA_LO     = 5'h0b;
  localparam logic [4:0] FW_DATA_HI     = 5'h0c;
  localparam logic [4:0] FW_HOST_TAR    = 5'h0d;
  localparam logic [4:0] FW_SYNC_CLK    = 5'h0f;
  localparam logic [4:0] MR_ADDR_LAST   = 5'h0a;
  localparam logic [4:0] MR_HOST_TAR    = 5'h0b;
  localparam logic [4:0] MR_TAKE_CLK    = 5'h0c;
  localparam logic [4:0] MR_SYNC_CLK    = 5'h0d;
  localparam logic [4:0] MR_DATA_LO     = 5'h0e;
  localparam logic [4:0] MR_DATA_HI     = 5'h0f;
  localparam logic [4:0] END_TAR0_CLK   = 5'h10;
  localparam logic [4:0] END_TAR1_CLK   = 5'h11;

  // ==========================================================
  // Address layout
  // ==========================================================
  localparam int         ADDR_W         = 32;
  localparam int         FW_ADDR_W      = 28;
  localparam int         ID_LSB         = 18;

  // Target frame tracking
  typedef enum logic [1:0] {
    CYC_IDLE  = 2'b00,
    CYC_START = 2'b01,
    CYC_FW_WR = 2'b10,
    CYC_MEM_RD = 2'b11
  } cyc_e;

endpackage

// file: logic/lpc_link_if.sv
// Shared four-bit bus and frame line between host end and target end.
// Assumes the bench supplies the clock to both ends; the bus idles high.
interface lpc_link_if;

  logic       lframe_n;
  logic [3:0] lad_host_o;
  logic       lad_host_oe_n;
  logic [3:0] lad_dev_o;
  logic       lad_dev_oe_n;
  logic [3:0] lad;

  // Resolved wire level; pull-ups hold an undriven bus at ones
  assign lad = !lad_host_oe_n ? lad_host_o :
               !lad_dev_oe_n  ? lad_dev_o  : 4'hf;

  modport host (
    output lframe_n,
    output lad_host_o,
    output lad_host_oe_n,
    input  lad
  );

  modport device (
    input  lframe_n,
    input  lad,
    output lad_dev_o,
    output lad_dev_oe_n
  );

endinterface

// file: logic/lpc_host_end.sv
// Host end: issues firmware-memory writes and memory reads on the link.
// Assumes cmd_* comes from logic on sys_clk and is held while cmd_valid.
module lpc_host_end (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  lpc_link_if.host                      link,
  input  wire logic                     cmd_valid,
  input  wire logic                     cmd_write,
  input  wire logic [lpc_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [7:0]               cmd_data,
  input  wire logic [3:0]               cmd_id,
  output logic                          cmd_ready,
  output logic                          rsp_valid,
  output logic                          rsp_ok,
  output logic [7:0]                    rsp_data
);
  import lpc_pkg::*;

  localparam logic [4:0] STEP_ABORT = 5'h1f;

  logic                step_q;
  logic [4:0]          clk_q;
  logic [4:0]          clk_d;
  logic                wr_q;
  logic [ADDR_W-1:0]   addr_q;
  logic [7:0]          data_q;
  logic [3:0]          id_q;
  logic [4:0]          field_d;
  logic                frame_n_q;
  logic [3:0]          lad_q;
  logic                lad_oe_n_q;
  logic                ready_q;
  logic                rsp_valid_q;
  logic                rsp_ok_q;
  logic [7:0]          rsp_data_q;

  // ==========================================================
  // Field source: returns {oe_n, nibble} for a given clock
  // ==========================================================
  function automatic logic [4:0] host_field(input logic wr, input logic [4:0] k,
                                            input logic [31:0] a, input logic [7:0] d,
                                            input logic [3:0] id);
    logic [31:0] sh;
    logic [4:0]  f;
    sh = wr ? (a >> {(FW_ADDR_LAST - k), 2'b00}) : (a >> {(MR_ADDR_LAST - k), 2'b00});
    f  = {1'b1, NIBBLE_ONES};
    if (k == 5'h01) begin
      f = {1'b0, wr ? START_FW_WRITE : START_LPC_MEM};
    end else if (k == CLK_SELECT) begin
      f = {1'b0, wr ? id : CYC_MEM_READ};
    end else if (wr) begin
      if (k <= FW_ADDR_LAST) f = {1'b0, sh[3:0]};
      else if (k == FW_SIZE_CLK) f = {1'b0, SIZE_ONE_BYTE};
      else if (k == FW_DATA_LO) f = {1'b0, d[3:0]};
      else if (k == FW_DATA_HI) f = {1'b0, d[7:4]};
      else if (k == FW_HOST_TAR) f = {1'b0, NIBBLE_ONES};
    end else begin
      if (k <= MR_ADDR_LAST) f = {1'b0, sh[3:0]};
      else if (k == MR_HOST_TAR) f = {1'b0, NIBBLE_ONES};
    end
    return f;
  endfunction

  assign clk_d   = clk_q + 5'h01;
  assign field_d = host_field(wr_q, clk_d, addr_q, data_q, id_q);

  // ==========================================================
  // Frame sequencer; each field changes on a rising edge
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    rsp_valid_q <= 1'b0;
    if (!rst_n) begin
      step_q     <= 1'b0;
      clk_q      <= 5'h00;
      frame_n_q  <= 1'b1;
      lad_q      <= NIBBLE_ONES;
      lad_oe_n_q <= 1'b1;
      ready_q    <= 1'b1;
      rsp_ok_q   <= 1'b0;
    end else if (!step_q && cmd_valid && ready_q) begin
      step_q     <= 1'b1;
      clk_q      <= 5'h01;
      ready_q    <= 1'b0;
      frame_n_q  <= 1'b0;
      lad_q      <= cmd_write ? START_FW_WRITE : START_LPC_MEM;
      lad_oe_n_q <= 1'b0;
    end else if (step_q && clk_q == STEP_ABORT) begin
      // One low clock with ones ends the frame
      step_q      <= 1'b0;
      clk_q       <= 5'h00;
      frame_n_q   <= 1'b1;
      lad_oe_n_q  <= 1'b1;
      ready_q     <= 1'b1;
      rsp_valid_q <= 1'b1;
      rsp_ok_q    <= 1'b0;
    end else if (step_q) begin
      frame_n_q <= 1'b1;
      if ((wr_q && clk_q == FW_SYNC_CLK && link.lad != SYNC_READY) ||
          (!wr_q && clk_q == MR_SYNC_CLK && link.lad != SYNC_READY)) begin
        clk_q      <= STEP_ABORT;
        frame_n_q  <= 1'b0;
        lad_q      <= NIBBLE_ONES;
        lad_oe_n_q <= 1'b0;
      end else if (clk_q == END_TAR1_CLK) begin
        // Bus is ours again from here on
        step_q      <= 1'b0;
        clk_q       <= 5'h00;
        ready_q     <= 1'b1;
        rsp_valid_q <= 1'b1;
        rsp_ok_q    <= 1'b1;
      end else begin
        clk_q      <= clk_d;
        lad_q      <= field_d[3:0];
        lad_oe_n_q <= field_d[4];
      end
    end
  end

  // Command capture at acceptance
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_q   <= 1'b0;
      addr_q <= '0;
      data_q <= 8'h00;
      id_q   <= 4'h0;
    end else if (!step_q && cmd_valid && ready_q) begin
      wr_q   <= cmd_write;
      addr_q <= cmd_addr;
      data_q <= cmd_data;
      id_q   <= cmd_id;
    end
  end

  // Read byte arrives low nibble first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rsp_data_q <= 8'h00;
    end else if (step_q && !wr_q && clk_q == MR_DATA_LO) begin
      rsp_data_q[3:0] <= link.lad;
    end else if (step_q && !wr_q && clk_q == MR_DATA_HI) begin
      rsp_data_q[7:4] <= link.lad;
    end
  end

  assign link.lframe_n      = frame_n_q;
  assign link.lad_host_o    = lad_q;
  assign link.lad_host_oe_n = lad_oe_n_q;
  assign cmd_ready          = ready_q;
  assign rsp_valid          = rsp_valid_q;
  assign rsp_ok             = rsp_ok_q;
  assign rsp_data           = rsp_data_q;

endmodule

// file: logic/lpc_target_end.sv
// Target end: decodes firmware-memory writes and memory reads, answers
// with sync and data. Assumes the host shares sys_clk, so link inputs
// are same-domain logic; identity straps are static pins.

// Summary of operation
// - Start 1110 with frame low: write
// - Last nibble before frame high is start
// - Write select nibble must equal strap pins
// - Write address: seven nibbles, highest first
// - Write size nibble 0000 means one byte
// - Write data in clocks 11, 12, low first
// - Host drives ones in 13, then floats
// - Ready sync 0000 in clock 15
// - Ones in 16, release; bus floats in 17
// - Start 0000 begins a memory cycle
// - Type bits 01; bit 1 low reads
// - Read address: eight nibbles, highest first
// - Host drives ones in 11, then floats
// - Take bus in 12, sync in 13
// - Read byte in 14, 15, low first
// - Ones in 16, release, float in 17
// - Fields valid and sampled on rising edge
// - Write size not 0000: ignore frame
// - Address strap bits mismatch: ignore read
// - Frame low mid-cycle terminates the cycle
module lpc_target_end (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  lpc_link_if.device                       link,
  input  wire logic [3:0]                  identity_strap_pins,
  output logic                             wr_valid,
  output logic [lpc_pkg::FW_ADDR_W-1:0]    wr_addr,
  output logic [7:0]                       wr_data,
  output logic                             rd_req,
  output logic [lpc_pkg::ADDR_W-1:0]       rd_addr,
  input  wire logic [7:0]                  rd_data
);
  import lpc_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  cyc_e                cyc_q;
  logic [4:0]          cnt_q;
  logic [4:0]          clk_now;
  logic [4:0]          clk_next;
  logic [3:0]          start_q;
  logic [ADDR_W-1:0]   addr_q;
  logic [ADDR_W-1:0]   addr_full;
  logic [7:0]          data_q;
  logic [3:0]          id_meta_q;
  logic [3:0]          id_q;
  logic [3:0]          lad_q;
  logic                lad_oe_n_q;
  logic                wr_valid_q;
  logic                rd_req_q;
  logic [ADDR_W-1:0]   rd_addr_q;

  // Identity bits carried inside a memory-cycle address
  function automatic logic [3:0] addr_id(input logic [ADDR_W-1:0] a);
    return a[ID_LSB +: 4];
  endfunction

  // Clock whose field is on the bus at this edge, and the one after
  assign clk_now   = cnt_q + 5'h01;
  assign clk_next  = cnt_q + 5'h02;
  assign addr_full = {addr_q[ADDR_W-5:0], link.lad};

  // ==========================================================
  // Strap capture through two flops
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      id_meta_q <= 4'h0;
      id_q      <= 4'h0;
    end else begin
      id_meta_q <= identity_strap_pins;
      id_q      <= id_meta_q;
    end
  end

  // ==========================================================
  // Frame decoder: fields are sampled on rising edges
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cyc_q   <= CYC_IDLE;
      cnt_q   <= 5'h00;
      start_q <= 4'h0;
    end else if (!link.lframe_n) begin
      // Frame low restarts; latest nibble wins
      cyc_q   <= CYC_START;
      cnt_q   <= 5'h01;
      start_q <= link.lad;
    end else begin
      cnt_q <= clk_now;
      unique case (cyc_q)
        CYC_IDLE: begin
          cnt_q <= 5'h00;
        end
        CYC_START: begin
          // Second clock picks the cycle kind
          if (start_q == START_FW_WRITE && link.lad == id_q) begin
            cyc_q <= CYC_FW_WR;
          end else if (start_q == START_LPC_MEM && link.lad[3:2] == CYCTYPE_MEM &&
                       link.lad[1] == DIR_READ) begin
            cyc_q <= CYC_MEM_RD;
          end else begin
            cyc_q <= CYC_IDLE;
          end
        end
        CYC_FW_WR: begin
          // Odd sizes drop the frame silently
          if (clk_now == FW_SIZE_CLK && link.lad != SIZE_ONE_BYTE) begin
            cyc_q <= CYC_IDLE;
          end else if (clk_now == END_TAR1_CLK) begin
            cyc_q <= CYC_IDLE;
          end
        end
        CYC_MEM_RD: begin
          // Strap mismatch in the address drops the frame
          if (clk_now == MR_ADDR_LAST && addr_id(addr_full) != id_q) begin
            cyc_q <= CYC_IDLE;
          end else if (clk_now == END_TAR1_CLK) begin
            cyc_q <= CYC_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Address and write-data assembly
  // ==========================================================
  // Address shifts in highest nibble first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addr_q <= '0;
    end else if (link.lframe_n && (cyc_q == CYC_FW_WR || cyc_q == CYC_MEM_RD)) begin
      // A write address ends at clock 9, so its size nibble never shifts in
      if (clk_now <= ((cyc_q == CYC_FW_WR) ? FW_ADDR_LAST : MR_ADDR_LAST)) begin
        addr_q <= addr_full;
      end
    end
  end

  // Write byte lands low nibble first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      data_q <= 8'h00;
    end else if (link.lframe_n && cyc_q == CYC_FW_WR) begin
      if (clk_now == FW_DATA_LO) begin
        data_q[3:0] <= link.lad;
      end else if (clk_now == FW_DATA_HI) begin
        data_q[7:4] <= link.lad;
      end
    end
  end

  // ==========================================================
  // Bus drive: released from the clock after an edge sees the frame line low
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lad_q      <= NIBBLE_ONES;
      lad_oe_n_q <= 1'b1;
    end else if (!link.lframe_n) begin
      lad_q      <= NIBBLE_ONES;
      lad_oe_n_q <= 1'b1;
    end else if (cyc_q == CYC_FW_WR) begin
      // Floating clock 14 first, then ready sync and ones
      lad_oe_n_q <= !(clk_next == FW_SYNC_CLK || clk_next == END_TAR0_CLK);
      lad_q      <= (clk_next == FW_SYNC_CLK) ? SYNC_READY : NIBBLE_ONES;
      if (clk_now == FW_SIZE_CLK && link.lad != SIZE_ONE_BYTE) begin
        lad_oe_n_q <= 1'b1;
      end
    end else if (cyc_q == CYC_MEM_RD) begin
      lad_oe_n_q <= 1'b1;
      lad_q      <= NIBBLE_ONES;
      // Take the bus, sync, data, then ones
      if (clk_next >= MR_TAKE_CLK && clk_next <= END_TAR0_CLK) begin
        lad_oe_n_q <= 1'b0;
      end
      if (clk_next == MR_SYNC_CLK) begin
        lad_q <= SYNC_READY;
      end else if (clk_next == MR_DATA_LO) begin
        lad_q <= rd_data[3:0];
      end else if (clk_next == MR_DATA_HI) begin
        lad_q <= rd_data[7:4];
      end
      // End with ones in clock 16, float in 17
    end else begin
      lad_q      <= NIBBLE_ONES;
      lad_oe_n_q <= 1'b1;
    end
  end

  // ==========================================================
  // User-side strobes
  // ==========================================================
  // Write is handed on with the sync, so a frame aborted before clock 15 never writes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_valid_q <= 1'b0;
    end else begin
      wr_valid_q <= link.lframe_n && cyc_q == CYC_FW_WR && clk_next == FW_SYNC_CLK;
    end
  end

  // Read request as soon as the address and strap check are done
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_req_q  <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      rd_req_q <= link.lframe_n && cyc_q == CYC_MEM_RD && clk_now == MR_ADDR_LAST &&
                  addr_id(addr_full) == id_q;
      if (link.lframe_n && cyc_q == CYC_MEM_RD && clk_now == MR_ADDR_LAST) begin
        rd_addr_q <= addr_full;
      end
    end
  end

  assign link.lad_dev_o    = lad_q;
  assign link.lad_dev_oe_n = lad_oe_n_q;
  assign wr_valid          = wr_valid_q;
  assign wr_addr           = addr_q[FW_ADDR_W-1:0];
  assign wr_data           = data_q;
  assign rd_req            = rd_req_q;
  assign rd_addr           = rd_addr_q;

endmodule

// file: tb/lpc_link_properties.sv
// Concurrent checks on the link that joins the host end to the target end.
// Assumes both ends share sys_clk and the frame line idles high.
module lpc_link_properties
  import lpc_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       lframe_n,
  input wire logic [3:0] lad_host_o,
  input wire logic       lad_host_oe_n,
  input wire logic [3:0] lad_dev_o,
  input wire logic       lad_dev_oe_n,
  input wire logic [3:0] lad
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] clk_no_q;
  logic [3:0] start_q;
  logic       fw;
  logic       mr;

  // ==========================================================
  // Frame tracking
  // ==========================================================
  // Field clock number seen at this edge; parks at 31 so idle is obvious
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clk_no_q <= 5'h00;
    end else if (!lframe_n) begin
      clk_no_q <= CLK_SELECT;
    end else if (clk_no_q != 5'h00 && clk_no_q != 5'h1f) begin
      clk_no_q <= clk_no_q + 5'h01;
    end
  end

  // Last nibble latched with the frame line low is the start field
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      start_q <= NIBBLE_ONES;
    end else if (!lframe_n) begin
      start_q <= lad;
    end
  end

  assign fw = (start_q == START_FW_WRITE);
  assign mr = (start_q == START_LPC_MEM);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Properties
  // ==========================================================
  a_idle_quiet:
    assert property ((clk_no_q == 5'h00 || clk_no_q > END_TAR1_CLK) |-> lad_dev_oe_n)
    else $error("target drives the bus outside a frame");
  a_fw_no_early:
    assert property (fw && clk_no_q inside {[2:14]} |-> lad_dev_oe_n)
    else $error("target drives before the write sync clock");
  a_fw_sync_seq:
    assert property (fw && clk_no_q == FW_SYNC_CLK && !lad_dev_oe_n |-> lad == SYNC_READY
      ##1 (!lad_dev_oe_n && lad == NIBBLE_ONES) ##1 lad_dev_oe_n)
    else $error("write sync, ones and release out of order");
  a_rd_no_early:
    assert property (mr && clk_no_q inside {[2:11]} |-> lad_dev_oe_n)
    else $error("target drives before the read takeover clock");
  a_rd_answer_seq:
    assert property (mr && clk_no_q == MR_TAKE_CLK && !lad_dev_oe_n |-> lad == NIBBLE_ONES
      ##1 lad == SYNC_READY ##1 !lad_dev_oe_n [*2] ##1 (!lad_dev_oe_n && lad == NIBBLE_ONES)
      ##1 lad_dev_oe_n)
    else $error("read answer sequence wrong");
  a_abort_release:
    assert property (!lframe_n |=> lad_dev_oe_n)
    else $error("target still drives after the frame line went low");
  a_one_driver:
    assert property (!lad_dev_oe_n |-> lad_host_oe_n)
    else $error("host and target drive the bus together");
  a_host_fw_tar:
    assert property (fw && clk_no_q == FW_HOST_TAR |-> (!lad_host_oe_n && lad == NIBBLE_ONES)
      ##1 lad_host_oe_n)
    else $error("host write turnaround wrong");
  a_host_rd_tar:
    assert property (mr && clk_no_q == MR_HOST_TAR |-> (!lad_host_oe_n && lad == NIBBLE_ONES)
      ##1 lad_host_oe_n)
    else $error("host read turnaround wrong");
  a_fw_size_one:
    assert property (fw && clk_no_q == FW_SIZE_CLK |-> lad == SIZE_ONE_BYTE)
    else $error("write size nibble not one byte");

  c_fw_sync: cover property (fw && clk_no_q == FW_SYNC_CLK && !lad_dev_oe_n);
  c_rd_sync: cover property (mr && clk_no_q == MR_SYNC_CLK && !lad_dev_oe_n);
  c_abort: cover property (!lframe_n && lad == NIBBLE_ONES && clk_no_q > CLK_SELECT);
endmodule

// file: tb/lpc_fw_write_mem_read_target_tb.sv
// Bench: host end and target end on one link, plus a second target fed by
// hand-built frames. Assumes package and interface are compiled first.
module lpc_fw_write_mem_read_target_tb;
  import lpc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [3:0]  STRAP = 4'h5; // Arbitrary strap value
  localparam logic [31:0] WA [3] = '{32'h0abc_1234, 32'h0fff_ffff, 32'h0000_0000};
  localparam logic [7:0]  WD [3] = '{8'h5a, 8'ha5, 8'h81};
  localparam logic [31:0] RA [3] = '{32'hff94_0abc, 32'hff80_0abc, 32'hffd7_ffff};
  localparam logic [7:0]  RD [3] = '{8'h3c, 8'h77, 8'hc3};
  localparam logic [2:0]  ROK    = 3'b101;

  logic        sys_clk, rst_n, cmd_valid, cmd_write, cmd_ready, rsp_valid, rsp_ok;
  logic        wr_valid, rd_req, wr_valid2, rd_req2;
  logic [31:0] cmd_addr, rd_addr, rd_addr2, got_addr;
  logic [7:0]  cmd_data, rsp_data, rd_data, wr_data, wr_data2, got_data;
  logic [3:0]  cmd_id;
  logic [27:0] wr_addr, wr_addr2;
  int          errors, n_checks, cycles, n_wr, n_rd, n_drv;

  lpc_link_if link();
  lpc_link_if link2();

  lpc_host_end lpc_host_end_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_id(cmd_id), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
    .rsp_data(rsp_data));
  lpc_target_end lpc_target_end_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
    .identity_strap_pins(STRAP), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data));
  // Second target only sees hand-built frames, none of them a valid read, so its read byte is never sent
  lpc_target_end lpc_target_end_i2 (.sys_clk(sys_clk), .rst_n(rst_n), .link(link2),
    .identity_strap_pins(STRAP), .wr_valid(wr_valid2), .wr_addr(wr_addr2),
    .wr_data(wr_data2), .rd_req(rd_req2), .rd_addr(rd_addr2), .rd_data(8'h00));
  lpc_link_properties lpc_link_properties_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .lframe_n(link.lframe_n), .lad_host_o(link.lad_host_o),
    .lad_host_oe_n(link.lad_host_oe_n), .lad_dev_o(link.lad_dev_o),
    .lad_dev_oe_n(link.lad_dev_oe_n), .lad(link.lad));

  // ==========================================================
  // Clock and hang guard
  // ==========================================================
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // About 270 cycles expected; far beyond that means a stuck handshake
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("ERROR run length expected 3000 cycles at most seen more");
      end_of_test();
    end
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One host command; counts user strobes of the target until the answer
  task automatic host_op(input logic wr, input logic [31:0] a, input logic [7:0] d,
                         input logic [3:0] id);
    n_wr = 0;
    n_rd = 0;
    while (cmd_ready !== 1'b1) @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_data = d;
    cmd_id = id;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    for (int i = 0; i < 40 && rsp_valid !== 1'b1; i++) begin
      if (wr_valid === 1'b1) begin
        n_wr++;
        got_addr = {4'h0, wr_addr};
        got_data = wr_data;
      end
      if (rd_req === 1'b1) begin
        n_rd++;
        got_addr = rd_addr;
      end
      @(negedge sys_clk);
    end
    check("answer", 32'h0000_0001, {31'h0, rsp_valid});
  endtask

  // Write frame body: start, select, address, size, data low/high, ones
  function automatic logic [51:0] fwb(input logic [3:0] s, input logic [3:0] sz,
                                      input logic [3:0] id);
    return {s, id, 28'h123_4567, sz, 4'ha, 4'h5, 4'hf};
  endfunction

  // Hand-built frame; pre rides one extra clock with the frame line low
  task automatic raw(input logic [3:0] pre, input logic [51:0] body, input int abort_at,
                     input logic resp);
    n_wr = 0;
    n_drv = 0;
    @(negedge sys_clk);
    link2.lframe_n = 1'b0;
    link2.lad_host_oe_n = 1'b0;
    link2.lad_host_o = pre;
    for (int i = 0; i < 13; i++) begin
      @(negedge sys_clk);
      link2.lframe_n = (i == 0 || i == abort_at) ? 1'b0 : 1'b1;
      link2.lad_host_o = (i == abort_at) ? 4'hf : body[51-4*i -: 4];
    end
    @(negedge sys_clk);
    link2.lad_host_oe_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (link2.lad_dev_oe_n === 1'b0) n_drv++;
      if (wr_valid2 === 1'b1) begin
        n_wr++;
        got_addr = {4'h0, wr_addr2};
        got_data = wr_data2;
      end
      @(negedge sys_clk);
    end
    check("raw drive clocks", resp ? 32'h0000_0002 : 32'h0000_0000, n_drv);
    check("raw write strobes", {31'h0, resp}, n_wr);
  endtask

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 32'h0000_0000;
    cmd_data = 8'h00;
    cmd_id = 4'h0;
    rd_data = 8'h00;
    link2.lframe_n = 1'b1;
    link2.lad_host_oe_n = 1'b1;
    link2.lad_host_o = 4'hf;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    // Back-to-back writes, address boundaries included
    for (int k = 0; k < 3; k++) begin
      host_op(1'b1, WA[k], WD[k], STRAP);
      check("write strobes", 32'h0000_0001, n_wr);
      check("write address", WA[k], got_addr);
      check("write data", {24'h0, WD[k]}, {24'h0, got_data});
      check("write done", 32'h0000_0001, {31'h0, rsp_ok});
    end
    host_op(1'b1, 32'h0123_4567, 8'h11, STRAP ^ 4'h1);
    check("foreign write strobes", 32'h0000_0000, n_wr);
    check("foreign write done", 32'h0000_0000, {31'h0, rsp_ok});
    // Reads; the foreign one in the middle must not disturb the next
    for (int k = 0; k < 3; k++) begin
      rd_data = RD[k];
      host_op(1'b0, RA[k], 8'h00, 4'h0);
      check("read done", {31'h0, ROK[k]}, {31'h0, rsp_ok});
      check("read strobes", {31'h0, ROK[k]}, n_rd);
      if (ROK[k]) begin
        check("read address", RA[k], got_addr);
        check("read data", {24'h0, RD[k]}, {24'h0, rsp_data});
      end
    end
    // Broken and awkward frames on the second link
    raw(4'h0, fwb(START_FW_WRITE, SIZE_ONE_BYTE, STRAP), -1, 1'b1);
    check("raw write address", 32'h0123_4567, got_addr);
    check("raw write data", 32'h0000_005a, {24'h0, got_data});
    raw(START_FW_WRITE, fwb(4'h9, SIZE_ONE_BYTE, STRAP), -1, 1'b0);
    raw(4'h0, fwb(START_FW_WRITE, 4'h1, STRAP), -1, 1'b0);
    raw(4'h0, fwb(START_FW_WRITE, SIZE_ONE_BYTE, STRAP), 6, 1'b0);
    raw(4'h0, fwb(START_LPC_MEM, 4'h0, 4'h6), -1, 1'b0);
    raw(4'h0, fwb(START_LPC_MEM, 4'h0, 4'h8), -1, 1'b0);
    end_of_test();
  end
endmodule
